// ==== hw/hbc_top.sv ====
// Notes on behaviour
// RL1: Every comparator has its own enable; a disabled one never matches.
// RL2: A breakpoint matches addresses from start to end, both bounds included.
// RL3: With exclusive set, a breakpoint matches addresses outside its range.
// RL4: Data and other breakpoints match off, writes, reads or any access.
// RL5: Skip counter ignores that many events; halt once the count is zero.
// RL6: The skip counter decrements on events only while decrementing is on.
// RL7: Restore-on-break reloads the restart skip value after each break.
// RL8: Group matches combine by OR, or by AND when AND-all is set.
// RL9: Data breakpoints watch primary generator or data-memory modifier.
// RL10: Two data comparators are ORed into one data condition.
// RL11: Four instruction comparators watch executed addresses, ORed into one.
// RL12: Program-memory breakpoints watch secondary generator or its modifier.
// RL13: I/O breakpoints watch the I/O address bus, DMA and host included.
// RL14: External-port breakpoints watch accesses through the external port.
// RL15: Break output asserts two cycles after the break condition.
// RL16: Controller avoids instruction breaks where a jump would be illegal.
// RL17: A single address is trapped by programming start equal to end.
// RL18: Configuration is loaded by the controller and held until rewritten.
module hbc_top #(
    parameter int AW = hbc_pkg::HBC_AW,
    parameter int SW = hbc_pkg::HBC_SW
) (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_cfg_wr,
    input wire hbc_pkg::hbc_bp_cfg_t i_data_cfg [hbc_pkg::HBC_NUM_DATA],
    input wire hbc_pkg::hbc_bp_cfg_t i_instr_cfg [hbc_pkg::HBC_NUM_INSTR],
    input wire hbc_pkg::hbc_bp_cfg_t i_other_cfg [hbc_pkg::HBC_NUM_OTHER],
    input wire hbc_pkg::hbc_ctl_t i_ctl,
    input wire logic i_restart,
    input wire hbc_pkg::hbc_acc_t i_dbus,
    input wire hbc_pkg::hbc_dsrc_t i_dbus_src,
    input wire hbc_pkg::hbc_acc_t i_instr,
    input wire hbc_pkg::hbc_acc_t i_iobus,
    input wire hbc_pkg::hbc_acc_t i_epbus,
    output logic o_hw_break,
    output logic o_event,
    output logic [2:0] o_group_hit,
    output logic [SW-1:0] o_skip_count
);
    localparam int ND = hbc_pkg::HBC_NUM_DATA;
    localparam int NI = hbc_pkg::HBC_NUM_INSTR;
    localparam int NO = hbc_pkg::HBC_NUM_OTHER;

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (AW != hbc_pkg::HBC_AW) begin : g_aw_chk
        $error("AW must equal the package address width");
    end
    if (SW != hbc_pkg::HBC_SW) begin : g_sw_chk
        $error("SW must equal the package skip width");
    end
    // The break pipeline below is built with exactly two register stages
    if (hbc_pkg::HBC_BREAK_LATENCY != 2) begin : g_lat_chk
        $error("break latency must be two cycles");
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    // Held so the core buses never see a half-written range
    hbc_pkg::hbc_bp_cfg_t data_cfg_q [ND];
    hbc_pkg::hbc_bp_cfg_t instr_cfg_q [NI];
    hbc_pkg::hbc_bp_cfg_t other_cfg_q [NO];
    hbc_pkg::hbc_ctl_t ctl_q;

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int k = 0; k < ND; k++) begin
                data_cfg_q[k] <= '0;
            end
            for (int k = 0; k < NI; k++) begin
                instr_cfg_q[k] <= '0;
            end
            for (int k = 0; k < NO; k++) begin
                other_cfg_q[k] <= '0;
            end
            ctl_q <= '0;
        end else if (i_cfg_wr) begin // RL18
            data_cfg_q <= i_data_cfg;
            instr_cfg_q <= i_instr_cfg;
            other_cfg_q <= i_other_cfg;
            ctl_q <= i_ctl;
        end
    end

    // ------------------------------------------------------------
    // Comparators
    // ------------------------------------------------------------
    logic [ND-1:0] data_hit;
    logic [NI-1:0] instr_hit;
    logic [NO-1:0] other_hit;
    logic [ND-1:0] data_en;
    logic [NI-1:0] instr_en;
    logic [NO-1:0] other_en;
    logic data_src_ok;
    logic prog_src_ok;
    hbc_pkg::hbc_acc_t other_acc [NO];

    assign data_src_ok = i_dbus_src.primary_data_addr_generator
        || i_dbus_src.data_memory_modifier; // RL9
    assign prog_src_ok = i_dbus_src.secondary_data_addr_generator
        || i_dbus_src.program_memory_modifier; // RL12
    assign other_acc[hbc_pkg::HBC_OTH_PROG] = i_dbus; // RL12
    assign other_acc[hbc_pkg::HBC_OTH_IO] = i_iobus; // RL13
    assign other_acc[hbc_pkg::HBC_OTH_EXT] = i_epbus; // RL14

    for (genvar g = 0; g < ND; g++) begin : g_data
        assign data_en[g] = data_cfg_q[g].en
            && data_cfg_q[g].mode != hbc_pkg::HBC_MODE_OFF;
        hbc_cmp #(.USE_MODE(1'b1)) u_cmp (
            .i_cfg(data_cfg_q[g]),
            .i_acc(i_dbus),
            .i_src_ok(data_src_ok),
            .o_match(data_hit[g])
        );
    end
    for (genvar g = 0; g < NI; g++) begin : g_instr
        assign instr_en[g] = instr_cfg_q[g].en;
        hbc_cmp #(.USE_MODE(1'b0)) u_cmp (
            .i_cfg(instr_cfg_q[g]),
            .i_acc(i_instr),
            .i_src_ok(1'b1),
            .o_match(instr_hit[g])
        ); // RL11
    end
    for (genvar g = 0; g < NO; g++) begin : g_other
        assign other_en[g] = other_cfg_q[g].en
            && other_cfg_q[g].mode != hbc_pkg::HBC_MODE_OFF;
        hbc_cmp #(.USE_MODE(1'b1)) u_cmp (
            .i_cfg(other_cfg_q[g]),
            .i_acc(other_acc[g]),
            .i_src_ok(g == hbc_pkg::HBC_OTH_PROG ? prog_src_ok : 1'b1),
            .o_match(other_hit[g])
        );
    end

    // ------------------------------------------------------------
    // Group and composite conditions
    // ------------------------------------------------------------
    // AND is taken over enabled members only, so a disabled one never
    // holds a group open or closed
    logic data_grp;
    logic instr_grp;
    logic other_grp;
    logic [2:0] grp_hit;
    logic [2:0] grp_en;
    logic comp_hit;

    assign data_grp = ctl_q.data_and_all
        ? (|data_en) && ((data_hit | ~data_en) == '1)
        : |data_hit; // RL8 RL10
    assign instr_grp = ctl_q.instr_and_all
        ? (|instr_en) && ((instr_hit | ~instr_en) == '1)
        : |instr_hit; // RL8 RL11
    assign other_grp = ctl_q.other_and_all
        ? (|other_en) && ((other_hit | ~other_en) == '1)
        : |other_hit; // RL8
    assign grp_hit = {other_grp, instr_grp, data_grp};
    assign grp_en = {|other_en, |instr_en, |data_en};
    assign comp_hit = ctl_q.group_and_all
        ? (|grp_en) && ((grp_hit | ~grp_en) == 3'h7)
        : |grp_hit; // RL8

    // ------------------------------------------------------------
    // Skip counter and break pipeline
    // ------------------------------------------------------------
    logic ev_q;
    logic fire;
    logic [SW-1:0] cnt_q;
    logic [SW-1:0] cnt_d;
    logic [SW-1:0] restart_q;
    logic brk_q;
    logic [2:0] grp_q;
    logic cnt_zero;
    logic do_dec;

    assign cnt_zero = cnt_q == '0;
    // Without decrementing, every event breaks; skipping needs the count
    assign fire = ev_q && (!ctl_q.skip_dec_en || cnt_zero); // RL5 RL6
    assign do_dec = ev_q && ctl_q.skip_dec_en && !cnt_zero; // RL6
    assign cnt_d = i_cfg_wr ? i_ctl.skip_n
        : i_restart ? restart_q
        : (fire && ctl_q.skip_restore) ? restart_q // RL7
        : do_dec ? cnt_q - 1'b1 // RL5
        : cnt_q;

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ev_q <= 1'b0;
            grp_q <= 3'h0;
            brk_q <= 1'b0;
            cnt_q <= hbc_pkg::HBC_SKIP_RST;
            restart_q <= hbc_pkg::HBC_SKIP_RST;
        end else begin
            ev_q <= comp_hit; // RL15
            grp_q <= grp_hit;
            brk_q <= fire; // RL15
            cnt_q <= cnt_d;
            if (i_cfg_wr) begin
                restart_q <= i_ctl.skip_n;
            end
        end
    end

    assign o_hw_break = brk_q;
    assign o_event = ev_q;
    assign o_group_hit = grp_q;
    assign o_skip_count = cnt_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);

    AST_DIS_NO_MATCH: assert property ( // RL1
        !data_cfg_q[0].en |-> !data_hit[0] && !(data_grp && !data_hit[1]))
        else $error("disabled data comparator matched");
    AST_INCL_BOUNDS: assert property ( // RL2
        instr_cfg_q[0].en && !instr_cfg_q[0].excl && i_instr.valid
        && (i_instr.addr == instr_cfg_q[0].lo
        || i_instr.addr == instr_cfg_q[0].hi) |-> instr_hit[0])
        else $error("bound address did not match");
    AST_EXCL_INSIDE: assert property ( // RL3
        instr_cfg_q[1].excl && i_instr.addr >= instr_cfg_q[1].lo
        && i_instr.addr <= instr_cfg_q[1].hi |-> !instr_hit[1])
        else $error("exclusive breakpoint matched inside range");
    AST_MODE_WR: assert property ( // RL4
        data_cfg_q[0].mode == hbc_pkg::HBC_MODE_WR && !i_dbus.wr
        |-> !data_hit[0])
        else $error("write-only breakpoint matched a non-write");
    AST_DATA_SRC: assert property ( // RL9
        !data_src_ok |-> data_hit == '0)
        else $error("data breakpoint matched a foreign source");
    AST_BRK_LAT: assert property ( // RL15
        o_hw_break |-> $past(comp_hit, 2))
        else $error("break without condition two cycles before");
    AST_ZERO_HALTS: assert property ( // RL5
        comp_hit ##1 (cnt_zero || !ctl_q.skip_dec_en) |=> o_hw_break)
        else $error("break missing at zero count");
    AST_SKIP_DEC: assert property ( // RL6
        do_dec && !i_cfg_wr && !i_restart
        |=> !o_hw_break && o_skip_count == $past(cnt_q) - 1'b1)
        else $error("skipped event not counted down");
    AST_RESTORE: assert property ( // RL7
        fire && ctl_q.skip_restore && !i_cfg_wr
        |=> o_skip_count == restart_q)
        else $error("skip count not restored after break");
    AST_KEEP: assert property ( // RL7
        fire && !ctl_q.skip_restore && !i_cfg_wr && !i_restart
        |=> $stable(o_skip_count))
        else $error("skip count changed on break without restore");
    AST_CFG_HOLD: assert property ( // RL18
        !i_cfg_wr |=> $stable(ctl_q) && $stable(data_cfg_q[0]))
        else $error("configuration changed without a write");

    COV_DATA_BREAK: cover property (data_grp ##2 o_hw_break);
    COV_INSTR_BREAK: cover property (instr_grp ##2 o_hw_break);
    COV_SKIPPED: cover property (do_dec ##1 !o_hw_break);
    COV_AND_ALL: cover property (ctl_q.group_and_all && comp_hit);
endmodule // hbc_top

// ==== hw/hbc_pkg.sv ====
package hbc_pkg;

    // ------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------
    localparam int HBC_AW = 32;
    localparam int HBC_SW = 16;
    localparam int HBC_NUM_DATA = 2;
    localparam int HBC_NUM_INSTR = 4;
    localparam int HBC_NUM_OTHER = 3;
    localparam int HBC_BREAK_LATENCY = 2;

    // ------------------------------------------------------------
    // Positions of the other-group comparators
    // ------------------------------------------------------------
    localparam int HBC_OTH_PROG = 0;
    localparam int HBC_OTH_IO = 1;
    localparam int HBC_OTH_EXT = 2;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [HBC_SW-1:0] HBC_SKIP_RST = 16'h0000;

    typedef enum logic [1:0] {
        HBC_MODE_OFF = 2'b00,
        HBC_MODE_WR = 2'b01,
        HBC_MODE_RD = 2'b10,
        HBC_MODE_ANY = 2'b11
    } hbc_mode_t;

    typedef struct packed {
        logic en;
        logic excl;
        hbc_mode_t mode;
        logic [HBC_AW-1:0] lo;
        logic [HBC_AW-1:0] hi;
    } hbc_bp_cfg_t;

    typedef struct packed {
        logic valid;
        logic rd;
        logic wr;
        logic [HBC_AW-1:0] addr;
    } hbc_acc_t;

    typedef struct packed {
        logic primary_data_addr_generator;
        logic secondary_data_addr_generator;
        logic data_memory_modifier;
        logic program_memory_modifier;
    } hbc_dsrc_t;

    typedef struct packed {
        logic skip_dec_en;
        logic skip_restore;
        logic data_and_all;
        logic instr_and_all;
        logic other_and_all;
        logic group_and_all;
        logic [HBC_SW-1:0] skip_n;
    } hbc_ctl_t;

endpackage

// ==== hw/hbc_cmp.sv ====
module hbc_cmp #(
    parameter bit USE_MODE = 1'b1
) (
    input wire hbc_pkg::hbc_bp_cfg_t i_cfg,
    input wire hbc_pkg::hbc_acc_t i_acc,
    input wire logic i_src_ok,
    output logic o_match
);
    logic in_range;
    logic dir_ok;
    logic armed;

    // Both bounds count as inside
    assign in_range = (i_acc.addr >= i_cfg.lo)
        && (i_acc.addr <= i_cfg.hi); // RL2
    // Instruction fetches carry no direction, so the mode is not consulted
    assign dir_ok = !USE_MODE
        || (i_cfg.mode == hbc_pkg::HBC_MODE_ANY && (i_acc.rd || i_acc.wr))
        || (i_cfg.mode == hbc_pkg::HBC_MODE_WR && i_acc.wr)
        || (i_cfg.mode == hbc_pkg::HBC_MODE_RD && i_acc.rd); // RL4
    assign armed = i_cfg.en && i_acc.valid && i_src_ok; // RL1
    assign o_match = armed && dir_ok && (in_range ^ i_cfg.excl); // RL3
endmodule // hbc_cmp

// ==== sim/hbc_core_emu.sv ====
// ----------------------------------------
// Core bus driver and halt counter
// ----------------------------------------
module hbc_core_emu (
    input wire logic i_sys_clk,
    input wire logic i_hw_break,
    output hbc_pkg::hbc_acc_t o_dbus,
    output hbc_pkg::hbc_dsrc_t o_dbus_src,
    output hbc_pkg::hbc_acc_t o_instr,
    output hbc_pkg::hbc_acc_t o_iobus,
    output hbc_pkg::hbc_acc_t o_epbus,
    output logic [15:0] o_halts
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_dbus = '0;
        o_dbus_src = '0;
        o_instr = '0;
        o_iobus = '0;
        o_epbus = '0;
        o_halts = '0;
        forever begin
            @(posedge i_sys_clk);
            if (i_hw_break === 1'b1) begin
                o_halts <= o_halts + 16'h0001;
            end
        end
    end
    // One access for one cycle; released buses show the inverse pattern
    task automatic acc(input logic [1:0] k, input logic rd, input logic wr,
                       input logic [31:0] a, input logic [3:0] s);
        hbc_pkg::hbc_acc_t v;
        hbc_pkg::hbc_acc_t z;
        v = {1'b1, rd, wr, a};
        z = ~v;
        z.valid = 1'b0;
        @(negedge i_sys_clk);
        o_dbus = (k == 2'h0) ? v : z;
        o_instr = (k == 2'h1) ? v : z;
        o_iobus = (k == 2'h2) ? v : z;
        o_epbus = (k == 2'h3) ? v : z;
        o_dbus_src = s;
        @(negedge i_sys_clk);
        o_dbus = z;
        o_instr = z;
        o_iobus = z;
        o_epbus = z;
        o_dbus_src = ~s;
    endtask
endmodule // hbc_core_emu

// ==== sim/test_hbc_top.sv ====
module test_hbc_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] P = 4'h8;
    localparam logic [3:0] S = 4'h4;
    localparam logic [3:0] DMOD = 4'h2;
    localparam hbc_pkg::hbc_mode_t ANY = hbc_pkg::HBC_MODE_ANY;
    logic clk, rst_n, cfg_wr, restart, brk, evt;
    logic [2:0] grp;
    logic [15:0] skip, halts;
    hbc_pkg::hbc_bp_cfg_t dcfg [hbc_pkg::HBC_NUM_DATA];
    hbc_pkg::hbc_bp_cfg_t icfg [hbc_pkg::HBC_NUM_INSTR];
    hbc_pkg::hbc_bp_cfg_t ocfg [hbc_pkg::HBC_NUM_OTHER];
    hbc_pkg::hbc_ctl_t ctl;
    hbc_pkg::hbc_acc_t dbus, ibus, iobus, epbus;
    hbc_pkg::hbc_dsrc_t src;
    int num_errors, comparisons, exp_halts;
    hbc_top DUT (.i_sys_clk(clk), .i_resetn(rst_n), .i_cfg_wr(cfg_wr),
        .i_data_cfg(dcfg), .i_instr_cfg(icfg), .i_other_cfg(ocfg),
        .i_ctl(ctl), .i_restart(restart), .i_dbus(dbus),
        .i_dbus_src(src), .i_instr(ibus), .i_iobus(iobus),
        .i_epbus(epbus), .o_hw_break(brk), .o_event(evt),
        .o_group_hit(grp), .o_skip_count(skip));
    hbc_core_emu PART (.i_sys_clk(clk), .i_hw_break(brk), .o_dbus(dbus),
        .o_dbus_src(src), .o_instr(ibus), .o_iobus(iobus),
        .o_epbus(epbus), .o_halts(halts));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic hbc_pkg::hbc_bp_cfg_t mk(input logic x,
        input hbc_pkg::hbc_mode_t m, input logic [31:0] lo,
        input logic [31:0] hi);
        return {1'b1, x, m, lo, hi};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic clr();
        foreach (dcfg[i]) dcfg[i] = '0;
        foreach (icfg[i]) icfg[i] = '0;
        foreach (ocfg[i]) ocfg[i] = '0;
        ctl = '0;
    endtask
    task automatic wcfg();
        @(negedge clk);
        cfg_wr = 1'b1;
        @(negedge clk);
        cfg_wr = 1'b0;
    endtask
    // Hit shows one cycle after the access, the break one cycle later
    task automatic pb(input logic [1:0] k, input logic rd, input logic wr,
        input logic [31:0] a, input logic [3:0] s, input logic [2:0] eg,
        input logic eb);
        PART.acc(k, rd, wr, a, s);
        chk({28'h0, evt, grp}, {28'h0, |eg, eg});
        @(negedge clk);
        chk({31'h0, brk}, {31'h0, eb});
        if (eb) exp_halts++;
    endtask
    task automatic finish_test();
        $display("num_errors=%0d comparisons=%0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #50000;
        num_errors++;
        finish_test();
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        cfg_wr = 1'b0;
        restart = 1'b0;
        clr();
        repeat (4) @(negedge clk);
        chk({11'h0, brk, evt, grp, skip}, 32'h0);
        rst_n = 1'b1;
        dcfg[0] = mk(1'b0, ANY, 32'h100, 32'h1FF);
        wcfg();
        pb(0, 1, 0, 32'h100, P, 3'h1, 1);
        pb(0, 0, 1, 32'h1FF, P, 3'h1, 1);
        pb(0, 1, 0, 32'h200, P, 3'h0, 0);
        pb(0, 1, 0, 32'h0FF, P, 3'h0, 0);
        pb(0, 1, 0, 32'h150, 4'h0, 3'h0, 0);
        pb(0, 1, 0, 32'h150, DMOD, 3'h1, 1);
        pb(0, 1, 0, 32'h150, S, 3'h0, 0);
        for (int m = 0; m < 4; m++) begin
            dcfg[0].mode = hbc_pkg::hbc_mode_t'(m[1:0]);
            wcfg();
            pb(0, 1, 0, 32'h120, P, {2'h0, m[1]}, m[1]);
            pb(0, 0, 1, 32'h120, P, {2'h0, m[0]}, m[0]);
        end
        dcfg[0].en = 1'b0;
        wcfg();
        pb(0, 1, 0, 32'h120, P, 3'h0, 0);
        dcfg[0].en = 1'b1;
        pb(0, 1, 0, 32'h120, P, 3'h0, 0);
        clr();
        dcfg[1] = mk(1'b1, ANY, 32'h100, 32'h1FF);
        wcfg();
        pb(0, 1, 0, 32'h150, P, 3'h0, 0);
        pb(0, 1, 0, 32'h200, P, 3'h1, 1);
        dcfg[0] = mk(1'b0, ANY, 32'h100, 32'h1FF);
        dcfg[1] = mk(1'b0, ANY, 32'h180, 32'h2FF);
        wcfg();
        pb(0, 1, 0, 32'h120, P, 3'h1, 1);
        ctl.data_and_all = 1'b1;
        wcfg();
        pb(0, 1, 0, 32'h120, P, 3'h0, 0);
        pb(0, 1, 0, 32'h190, P, 3'h1, 1);
        clr();
        // Plain single-address traps, away from loop ends and branch slots
        foreach (icfg[i]) icfg[i] = mk(1'b0, hbc_pkg::HBC_MODE_OFF,
            32'h1000 + 32'(i) * 32'h10,
            32'h1000 + 32'(i) * 32'h10);
        wcfg();
        for (int i = 0; i < 4; i++) begin
            pb(1, 0, 0, 32'h1000 + 32'(i) * 32'h10, 0, 3'h2, 1);
            pb(1, 0, 0, 32'h1001 + 32'(i) * 32'h10, 0, 3'h0, 0);
        end
        clr();
        ocfg[hbc_pkg::HBC_OTH_PROG] = mk(1'b0, ANY, 32'h300, 32'h3FF);
        ocfg[hbc_pkg::HBC_OTH_IO] = mk(1'b0, hbc_pkg::HBC_MODE_WR,
            32'h300, 32'h3FF);
        ocfg[hbc_pkg::HBC_OTH_EXT] = mk(1'b0, hbc_pkg::HBC_MODE_RD,
            32'h300, 32'h3FF);
        wcfg();
        pb(0, 1, 0, 32'h310, S, 3'h4, 1);
        pb(0, 1, 0, 32'h310, 4'h1, 3'h4, 1);
        pb(0, 1, 0, 32'h310, P, 3'h0, 0);
        pb(2, 0, 1, 32'h310, 0, 3'h4, 1);
        pb(2, 1, 0, 32'h310, 0, 3'h0, 0);
        pb(3, 1, 0, 32'h310, 0, 3'h4, 1);
        pb(3, 0, 1, 32'h310, 0, 3'h0, 0);
        // Only one bus carries an access, so AND over all three never hits
        ctl.other_and_all = 1'b1;
        wcfg();
        pb(0, 1, 0, 32'h310, S, 3'h0, 0);
        ocfg[hbc_pkg::HBC_OTH_IO].en = 1'b0;
        ocfg[hbc_pkg::HBC_OTH_EXT].mode = hbc_pkg::HBC_MODE_OFF;
        wcfg();
        pb(0, 1, 0, 32'h310, S, 3'h4, 1);
        clr();
        icfg[0] = mk(1'b0, hbc_pkg::HBC_MODE_OFF, 32'h1000, 32'h10FF);
        icfg[1] = mk(1'b0, hbc_pkg::HBC_MODE_OFF, 32'h1080, 32'h11FF);
        ctl.instr_and_all = 1'b1;
        wcfg();
        pb(1, 0, 0, 32'h1010, 0, 3'h0, 0);
        pb(1, 0, 0, 32'h1090, 0, 3'h2, 1);
        clr();
        dcfg[0] = mk(1'b0, ANY, 32'h300, 32'h3FF);
        ocfg[hbc_pkg::HBC_OTH_PROG] = dcfg[0];
        ctl.group_and_all = 1'b1;
        wcfg();
        pb(0, 1, 0, 32'h310, P | S, 3'h5, 1);
        PART.acc(0, 1, 0, 32'h310, P);
        chk({28'h0, evt, grp}, 32'h1);
        @(negedge clk);
        chk({31'h0, brk}, 32'h0);
        clr();
        dcfg[0] = mk(1'b0, ANY, 32'h100, 32'h1FF);
        ctl.skip_n = 16'h0002;
        ctl.skip_dec_en = 1'b1;
        for (int r = 0; r < 2; r++) begin
            ctl.skip_restore = r[0];
            wcfg();
            chk({16'h0, skip}, 32'h2);
            pb(0, 1, 0, 32'h100, P, 3'h1, 0);
            chk({16'h0, skip}, 32'h1);
            pb(0, 1, 0, 32'h100, P, 3'h1, 0);
            chk({16'h0, skip}, 32'h0);
            pb(0, 1, 0, 32'h100, P, 3'h1, 1);
            chk({16'h0, skip}, r ? 32'h2 : 32'h0);
        end
        ctl.skip_restore = 1'b0;
        wcfg();
        pb(0, 1, 0, 32'h100, P, 3'h1, 0);
        @(negedge clk);
        restart = 1'b1;
        @(negedge clk);
        restart = 1'b0;
        chk({16'h0, skip}, 32'h2);
        ctl.skip_dec_en = 1'b0;
        wcfg();
        pb(0, 1, 0, 32'h100, P, 3'h1, 1);
        chk({16'h0, skip}, 32'h2);
        // The halt counter sees the last pulse only at its closing edge
        @(negedge clk);
        chk({16'h0, halts}, 32'(exp_halts));
        finish_test();
    end
endmodule // test_hbc_top
